// *** testbench/bor_checker.sv ***
// Port assertions for the bus options register
`timescale 1ns/1ps
`default_nettype none
module bor_checker #(
	parameter LW = 16
) (
	input wire logic          ref_clk,
	input wire logic          rst_b,
	input wire logic          soft_rst,
	input wire logic [7:0]    reg_addr,
	input wire logic [31:0]   reg_wdata,
	input wire logic          reg_wr,
	input wire logic          reg_rd,
	input wire logic [31:0]   reg_rdata,
	input wire logic          bw_req_valid,
	input wire logic [LW-1:0] bw_req_len,
	input wire logic          bw_chk_done,
	input wire logic          bw_ack_type_error,
	input wire logic [31:0]   bus_options_q,
	input wire logic [16:0]   max_rec_bytes
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	// Options write strobe
	wire wr_opt = reg_wr && reg_addr == 8'h20 && !soft_rst;
	sequence s_oversize;
		bw_req_valid && bw_req_len > max_rec_bytes;
	endsequence
	sequence s_fits;
		bw_req_valid && bw_req_len <= max_rec_bytes;
	endsequence
	chk_rsvd_zero: assert property (
		{bus_options_q[26:24], bus_options_q[11:8], bus_options_q[5:3]} == 10'h000)
		else $error("reserved bits not zero");
	chk_speed_code: assert property (bus_options_q[2:0] == 3'h2)
		else $error("speed code wrong");
	chk_max_bytes: assert property (
		max_rec_bytes == 17'h1 << (bus_options_q[15:12] + 5'h01) && bus_options_q[15])
		else $error("max request size wrong");
	chk_ack_oversize: assert property (s_oversize |=> bw_chk_done && bw_ack_type_error)
		else $error("oversize write not flagged");
	chk_ack_fits: assert property (s_fits |=> bw_chk_done && !bw_ack_type_error)
		else $error("fitting write flagged");
	chk_mrec_soft: assert property (soft_rst && !reg_wr |=> $stable(bus_options_q[15:12]))
		else $error("max request moved on soft reset");
	chk_pmc_soft: assert property (soft_rst |=> !bus_options_q[27])
		else $error("power flag kept on soft reset");
	chk_write_fields: assert property (wr_opt |=>
		(bus_options_q & 32'hf8ff_00c0) == ($past(reg_wdata) & 32'hf8ff_00c0))
		else $error("writable fields not stored");
	chk_mrec_write: assert property (wr_opt && reg_wdata[15] |=>
		bus_options_q[15:12] == $past(reg_wdata[15:12]))
		else $error("max request not stored");
	chk_read_data: assert property (reg_rd && reg_addr == 8'h20 |=> reg_rdata == $past(bus_options_q))
		else $error("read data wrong");
endmodule
bind bor_top bor_checker #(.LW(LW)) u_checker (.ref_clk, .rst_b, .soft_rst, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .bw_req_valid, .bw_req_len, .bw_chk_done,
	.bw_ack_type_error, .bus_options_q, .max_rec_bytes);
`default_nettype wire

// *** testbench/bus_options_register_test.sv ***
// Self-checking bench for the bus options register
`timescale 1ns/1ps
`default_nettype none
module bus_options_register_test;
	logic        ref_clk = '0, rst_b = '0, soft_rst = '0, reg_wr = '0, reg_rd = '0;
	logic        link_on_control = '0, rom_changed = '0, bus_reset = '0, bw_req_valid = '0;
	logic [7:0]  reg_addr = '0;
	logic [15:0] bw_req_len = '0;
	logic [31:0] reg_wdata = '0, reg_rdata, bus_options_q, seed = 32'h0000_cc29, m, w;
	logic [16:0] max_rec_bytes, lb;
	logic        bw_chk_done, bw_ack_type_error;
	int          errors = 0, compares = 0, cyc = 0;
	always #4 ref_clk = ~ref_clk;
	bor_top u_dut (.ref_clk, .rst_b, .soft_rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .link_on_control, .rom_changed, .bus_reset, .bw_req_valid, .bw_req_len,
		.bw_chk_done, .bw_ack_type_error, .bus_options_q, .max_rec_bytes);
	// Xorshift source
	function automatic logic [31:0] nxt_rand();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	// Expected quadlet after a write; low max-request codes are refused
	function automatic logic [31:0] exp_opt(input logic [31:0] o, input logic [31:0] v);
		return {v[31:27], 3'h0, v[23:16], (v[15] ? v[15:12] : o[15:12]), 4'h0, v[7:6], 6'h02};
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] want);
		compares++;
		if (seen !== want) begin
			errors++;
			$display("unexpected %0t seen %h want %h", $time, seen, want);
		end
	endtask
	task automatic end_sim;
		if (errors == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge ref_clk);
		reg_wr <= 1'b1;
		reg_addr <= a;
		reg_wdata <= v;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] want);
		@(posedge ref_clk);
		reg_rd <= 1'b1;
		reg_addr <= a;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, want);
	endtask
	// Length check, expectation from the modelled code
	task automatic len(input logic [15:0] l);
		@(posedge ref_clk);
		bw_req_valid <= 1'b1;
		bw_req_len <= l;
		@(posedge ref_clk);
		bw_req_valid <= 1'b0;
		#1 chk({bw_chk_done, bw_ack_type_error},
			{1'b1, {1'b0, l} > (17'h1 << (m[15:12] + 5'h01))});
	endtask
	// Hang guard
	always @(posedge ref_clk) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			errors++;
			end_sim;
		end
	end
	initial begin
		repeat (12) @(posedge ref_clk);
		rst_b <= 1'b1;
		m = 32'h0000_a002;
		rd(8'h20, m);
		// Random writes, all-zero and all-one corners first
		for (int i = 0; i < 40; i++) begin
			w = i < 2 ? {32{i[0]}} : nxt_rand();
			wr(8'h20, w);
			m = exp_opt(m, w);
			rd(8'h20, m);
			len(nxt_rand() >> 16);
		end
		// Legal codes 8 to 14 at their size boundary; code 15 wraps to lengths 0 and 1
		for (int c = 8; c < 16; c++) begin
			wr(8'h20, c << 12);
			m = exp_opt(m, c << 12);
			lb = 17'h1 << (c + 1);
			len(lb[15:0]);
			len(lb[15:0] + 16'h0001);
		end
		// Status flags: oversize and link-on write set them, write-one clears
		wr(8'h20, 32'h0000_a0c0);
		m = exp_opt(m, 32'h0000_a0c0);
		wr(8'h3C, 32'h0000_0007);
		rd(8'h3C, 32'h0000_0000);
		len(16'h0801);
		@(posedge ref_clk) link_on_control <= 1'b1;
		wr(8'h20, m);
		rd(8'h3C, 32'h0000_0006);
		wr(8'h3C, 32'h0000_0006);
		rd(8'h3C, 32'h0000_0000);
		// Unmapped place
		wr(8'h44, 32'hffff_ffff);
		rd(8'h44, 32'h0000_0000);
		rd(8'h20, m);
		// Soft reset clears power flag, keeps max request
		wr(8'h20, 32'h0800_90c0);
		m = exp_opt(m, 32'h0800_90c0);
		@(posedge ref_clk) soft_rst <= 1'b1;
		@(posedge ref_clk) soft_rst <= 1'b0;
		m[27] = 1'b0;
		rd(8'h20, m);
		rd(8'h3C, 32'h0000_0000);
		// ROM change then bus reset advances generation, 3 wraps to 0
		@(posedge ref_clk) rom_changed <= 1'b1;
		link_on_control <= 1'b0;
		@(posedge ref_clk) rom_changed <= 1'b0;
		rd(8'h3C, 32'h0000_0001);
		@(posedge ref_clk) bus_reset <= 1'b1;
		@(posedge ref_clk) bus_reset <= 1'b0;
		m[7:6] = m[7:6] + 2'h1;
		rd(8'h20, m);
		rd(8'h3C, 32'h0000_0000);
		// Bus reset with nothing pending keeps the generation
		@(posedge ref_clk) bus_reset <= 1'b1;
		@(posedge ref_clk) bus_reset <= 1'b0;
		rd(8'h20, m);
		// Hardware reset in mid-run reloads 2048 bytes
		@(posedge ref_clk) rst_b <= 1'b0;
		@(posedge ref_clk) rst_b <= 1'b1;
		m = 32'h0000_a002;
		rd(8'h20, m);
		rd(8'h3C, 32'h0000_0000);
		end_sim;
	end
endmodule
`default_nettype wire

// *** verilog/bor_field.v ***
// Writable register field with hardware and optional software reset
`timescale 1ns/1ps
`default_nettype none

module bor_field #(
	parameter         W       = 4,
	parameter [W-1:0] RST_VAL = {W{1'b0}},
	parameter         SOFT    = 1
) (
	input  wire         ref_clk,
	input  wire         rst_b,
	input  wire         soft_rst,
	input  wire         wr_en,
	input  wire [W-1:0] wdata,
	output reg  [W-1:0] q_ff
);

	// Soft reset reloads only when SOFT is set
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			q_ff <= RST_VAL;
		end else if ((SOFT != 0) && soft_rst) begin
			q_ff <= RST_VAL;
		end else if (wr_en) begin
			q_ff <= wdata;
		end
	end

endmodule

`default_nettype wire

// *** verilog/bor_lencheck.v ***
// Block write length check against the max-request size
`timescale 1ns/1ps
`default_nettype none

module bor_lencheck #(
	parameter LW = 16
) (
	input  wire          ref_clk,
	input  wire          rst_b,
	input  wire          req_valid,
	input  wire [LW-1:0] req_len,
	input  wire [3:0]    mrec_code,
	output reg           done_ff,
	output reg           err_ff,
	output wire [16:0]   max_bytes
);

	// Payload limit 2^(code+1); code 15 gives 65536
	assign max_bytes = {16'h0000, 1'b1} << ({1'b0, mrec_code} + 5'h01);

	wire over = ({{(17 - LW){1'b0}}, req_len} > max_bytes);

	// Verdict one cycle after the request
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			done_ff <= 1'b0;
			err_ff  <= 1'b0;
		end else begin
			done_ff <= req_valid;
			err_ff  <= req_valid & over;
		end
	end

endmodule

`default_nettype wire

// *** verilog/bor_regs.vh ***
// Constants of the bus options register block
//
// Behaviour
// - Bits 31 to 28 hold four writable capability flags (resource manager, cycle master, isochronous, bus manager).
// - Bit 27 is a writable power-management flag that resets to zero.
// - Bits 26 to 24 always read as zero.
// - Bits 23 to 16 hold a writable 8-bit cycle-master clock accuracy in ppm.
// - Bits 15 to 12 hold a writable max-request code; the payload limit is 2^(code+1) bytes, never below 512.
// - A received block write longer than the max-request size may be answered with ack_type_error.
// - The max-request code ignores software reset and loads 4'hA (2048 bytes) on hardware reset.
// - Bits 2 to 0 always read as 3'b010 (100, 200 and 400 Mbit/s).
// - Bits 7 and 6 hold a writable generation counter advanced when the ROM changed since the last bus reset.
// - Bits 11 to 8 and 5 to 3 always read as zero.
`ifndef BOR_REGS_VH
`define BOR_REGS_VH

// Register offsets
`define BOR_OPT_OFS      8'h20
`define BOR_STAT_OFS     8'h3C

// Field positions of the options quadlet
`define BOR_CAP_MSB      31
`define BOR_CAP_LSB      28
`define BOR_PMC_BIT      27
`define BOR_ACC_MSB      23
`define BOR_ACC_LSB      16
`define BOR_MREC_MSB     15
`define BOR_MREC_LSB     12
`define BOR_GEN_MSB      7
`define BOR_GEN_LSB      6
`define BOR_SPD_MSB      2
`define BOR_SPD_LSB      0

// Field positions of the status register
`define BOR_ST_PEND_BIT  0
`define BOR_ST_LWR_BIT   1
`define BOR_ST_ERR_BIT   2

// Reset and fixed values
`define BOR_CAP_RST      4'h0
`define BOR_PMC_RST      1'h0
`define BOR_ACC_RST      8'h00
`define BOR_MREC_RST     4'hA
`define BOR_MREC_MIN     4'h8
`define BOR_GEN_RST      2'h0
`define BOR_GEN_STEP     2'h1
`define BOR_SPD_CODE     3'h2
`define BOR_RSV_HI_VAL   3'h0
`define BOR_RSV_MID_VAL  4'h0
`define BOR_RSV_LO_VAL   3'h0
`define BOR_ZERO32       32'h0000_0000

`endif

// *** verilog/bor_top.v ***
// Bus options register with max-request length check
`timescale 1ns/1ps
`default_nettype none
`include "bor_regs.vh"

module bor_top #(
	parameter LW = 16
) (
	input  wire          ref_clk,
	input  wire          rst_b,
	input  wire          soft_rst,
	input  wire [7:0]    reg_addr,
	input  wire [31:0]   reg_wdata,
	input  wire          reg_wr,
	input  wire          reg_rd,
	output reg  [31:0]   reg_rdata,
	input  wire          link_on_control,
	input  wire          rom_changed,
	input  wire          bus_reset,
	input  wire          bw_req_valid,
	input  wire [LW-1:0] bw_req_len,
	output wire          bw_chk_done,
	output wire          bw_ack_type_error,
	output wire [31:0]   bus_options_q,
	output wire [16:0]   max_rec_bytes
);

	// Write decode; anything but the two mapped places is ignored
	wire wr_opt;
	wire wr_stat;

	assign wr_opt  = reg_wr && (reg_addr == `BOR_OPT_OFS);
	assign wr_stat = reg_wr && (reg_addr == `BOR_STAT_OFS);

	// Read decode; unmapped places read as zero
	wire rd_opt;
	wire rd_stat;

	assign rd_opt  = reg_rd && (reg_addr == `BOR_OPT_OFS);
	assign rd_stat = reg_rd && (reg_addr == `BOR_STAT_OFS);

	// Field slices of the write data
	wire [3:0] wd_cap;
	wire       wd_pmc;
	wire [7:0] wd_acc;
	wire [3:0] wd_mrec;
	wire [1:0] wd_gen;

	assign wd_cap  = reg_wdata[`BOR_CAP_MSB:`BOR_CAP_LSB];
	assign wd_pmc  = reg_wdata[`BOR_PMC_BIT];
	assign wd_acc  = reg_wdata[`BOR_ACC_MSB:`BOR_ACC_LSB];
	assign wd_mrec = reg_wdata[`BOR_MREC_MSB:`BOR_MREC_LSB];
	assign wd_gen  = reg_wdata[`BOR_GEN_MSB:`BOR_GEN_LSB];

	// Field write enables; a max-request code under 512 bytes is refused
	wire mrec_ok;
	wire wr_cap;
	wire wr_pmc;
	wire wr_acc;
	wire wr_mrec;
	wire wr_gen;

	assign mrec_ok = (wd_mrec >= `BOR_MREC_MIN);
	assign wr_cap  = wr_opt;
	assign wr_pmc  = wr_opt;
	assign wr_acc  = wr_opt;
	assign wr_mrec = wr_opt && mrec_ok;
	assign wr_gen  = wr_opt;

	// Field outputs
	wire [3:0] cap_q;
	wire [0:0] pmc_q;
	wire [7:0] acc_q;
	wire [3:0] mrec_q;

	// Capability flags; kept over software reset
	bor_field #(
		.W       (4),
		.RST_VAL (`BOR_CAP_RST),
		.SOFT    (0)
	) u_cap (
		.ref_clk  (ref_clk),
		.rst_b    (rst_b),
		.soft_rst (soft_rst),
		.wr_en    (wr_cap),
		.wdata    (wd_cap),
		.q_ff     (cap_q)
	);

	// Power-management flag; clears on either reset
	bor_field #(
		.W       (1),
		.RST_VAL (`BOR_PMC_RST),
		.SOFT    (1)
	) u_pmc (
		.ref_clk  (ref_clk),
		.rst_b    (rst_b),
		.soft_rst (soft_rst),
		.wr_en    (wr_pmc),
		.wdata    (wd_pmc),
		.q_ff     (pmc_q)
	);

	// Cycle-master clock accuracy in ppm
	bor_field #(
		.W       (8),
		.RST_VAL (`BOR_ACC_RST),
		.SOFT    (0)
	) u_acc (
		.ref_clk  (ref_clk),
		.rst_b    (rst_b),
		.soft_rst (soft_rst),
		.wr_en    (wr_acc),
		.wdata    (wd_acc),
		.q_ff     (acc_q)
	);

	// Max-request code; software reset never touches it
	bor_field #(
		.W       (4),
		.RST_VAL (`BOR_MREC_RST),
		.SOFT    (0)
	) u_mrec (
		.ref_clk  (ref_clk),
		.rst_b    (rst_b),
		.soft_rst (soft_rst),
		.wr_en    (wr_mrec),
		.wdata    (wd_mrec),
		.q_ff     (mrec_q)
	);

	// Generation counter and ROM-change pending flag
	reg  [1:0] gen_ff;
	reg  [1:0] nxt_gen;
	reg        pend_ff;
	reg        nxt_pend;

	// Bus-reset step and pending clear; the sum keeps its carry apart
	wire       ev_gen_adv;
	wire       ev_pend_clr;
	wire [2:0] gen_sum;

	assign ev_gen_adv  = bus_reset && pend_ff;
	assign ev_pend_clr = wr_stat && reg_wdata[`BOR_ST_PEND_BIT];
	assign gen_sum     = {1'b0, gen_ff} + {1'b0, `BOR_GEN_STEP}; // Wraps 3 to 0

	// Generation: a write in the same cycle beats the bus-reset step
	always @* begin
		nxt_gen = gen_ff;
		if (ev_gen_adv) begin
			nxt_gen = gen_sum[1:0];
		end
		if (wr_gen) begin
			nxt_gen = wd_gen;
		end
	end

	// Pending: a ROM change wins over a bus-reset or write-one clear, soft reset clears and wins over both
	always @* begin
		nxt_pend = pend_ff;
		if (ev_gen_adv || ev_pend_clr) begin
			nxt_pend = 1'b0;
		end
		if (rom_changed) begin
			nxt_pend = 1'b1;
		end
		if (soft_rst) begin
			nxt_pend = 1'b0;
		end
	end

	// Generation and pending registers
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			gen_ff  <= `BOR_GEN_RST;
			pend_ff <= 1'b0;
		end else begin
			gen_ff  <= nxt_gen;
			pend_ff <= nxt_pend;
		end
	end

	// Fixed and reserved parts of the quadlet
	wire [2:0] rsv_hi;
	wire [3:0] rsv_mid;
	wire [2:0] rsv_lo;
	wire [2:0] spd_code;

	assign rsv_hi   = `BOR_RSV_HI_VAL;
	assign rsv_mid  = `BOR_RSV_MID_VAL;
	assign rsv_lo   = `BOR_RSV_LO_VAL;
	assign spd_code = `BOR_SPD_CODE;

	// Assembled quadlet; fixed and reserved bits come from constants
	assign bus_options_q = {
		cap_q,
		pmc_q,
		rsv_hi,
		acc_q,
		mrec_q,
		rsv_mid,
		gen_ff,
		rsv_lo,
		spd_code
	};

	// Length check of received block writes
	bor_lencheck #(
		.LW (LW)
	) u_chk (
		.ref_clk   (ref_clk),
		.rst_b     (rst_b),
		.req_valid (bw_req_valid),
		.req_len   (bw_req_len),
		.mrec_code (mrec_q),
		.done_ff   (bw_chk_done),
		.err_ff    (bw_ack_type_error),
		.max_bytes (max_rec_bytes)
	);

	// Sticky status: write while link is on, oversize write seen
	reg  lwr_ff;
	reg  nxt_lwr;
	reg  err_seen_ff;
	reg  nxt_err_seen;

	// Status set events and write-one clears
	wire ev_lwr_set;
	wire ev_lwr_clr;
	wire ev_err_set;
	wire ev_err_clr;

	assign ev_lwr_set = wr_opt && link_on_control;
	assign ev_lwr_clr = wr_stat && reg_wdata[`BOR_ST_LWR_BIT];
	assign ev_err_set = bw_ack_type_error;
	assign ev_err_clr = wr_stat && reg_wdata[`BOR_ST_ERR_BIT];

	// Link-on write flag; a new event in the same cycle wins
	always @* begin
		nxt_lwr = lwr_ff;
		if (ev_lwr_clr) begin
			nxt_lwr = 1'b0;
		end
		if (ev_lwr_set) begin
			nxt_lwr = 1'b1;
		end
		if (soft_rst) begin
			nxt_lwr = 1'b0;
		end
	end

	// Oversize flag; a new event in the same cycle wins
	always @* begin
		nxt_err_seen = err_seen_ff;
		if (ev_err_clr) begin
			nxt_err_seen = 1'b0;
		end
		if (ev_err_set) begin
			nxt_err_seen = 1'b1;
		end
		if (soft_rst) begin
			nxt_err_seen = 1'b0;
		end
	end

	// Status registers
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			lwr_ff      <= 1'b0;
			err_seen_ff <= 1'b0;
		end else begin
			lwr_ff      <= nxt_lwr;
			err_seen_ff <= nxt_err_seen;
		end
	end

	// Status quadlet
	wire [31:0] stat_word;

	assign stat_word = {29'h0000_0000, err_seen_ff, lwr_ff, pend_ff};

	// Read data one cycle after the strobe, zero otherwise
	reg [31:0] nxt_rdata;

	always @* begin
		if (rd_opt) begin
			nxt_rdata = bus_options_q;
		end else if (rd_stat) begin
			nxt_rdata = stat_word;
		end else begin
			nxt_rdata = `BOR_ZERO32;
		end
	end

	// Read data register; zero between reads
	always @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= `BOR_ZERO32;
		end else begin
			reg_rdata <= nxt_rdata;
		end
	end

endmodule

`default_nettype wire
